// ### line_interface.sv
// line side interface: transmit rails and clock, receive capture, apb regs
//
// Implementation choices: the register addresses and the APB slave port.

// ****************************************************
// line interface top
// ****************************************************
// Summary of operation
// - dual-rail mode: plus rail for positive, minus rail for negative pulses
// - binary mode drives data on the plus output and holds minus low
// - transmit data changes on rising clock edge, or falling when inverted
// - plus force bit holds the plus output high
// - plus invert bit inverts plus output; force with invert gives low
// - minus force holds high, invert inverts, both together give low
// - out clock normally copies the transmit input clock, optional invert
// - during line or payload loopback the clock follows the receive clock
// - on transmit clock loss with switchover set, use the receive clock
// - dual-rail receive takes plus and minus pulses as AMI data
// - binary receive takes data on plus input, violations on minus input
// - receive inputs sampled on rising edge, or falling when inverted
// - receive plus invert bit flips the plus input polarity
// - binary mode counts cycles with violation high, or low when inverted
// - receive works with gapped or continuous line clocks up to 52MHz
module line_interface
  import line_if_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic fmt_plus,
  input wire logic fmt_minus,
  input wire logic fmt_nrz,
  output logic fmt_take,
  input wire logic dec_bpv,
  output logic dec_plus,
  output logic dec_minus,
  output logic dec_strobe,
  input wire logic tx_input_clock,
  output logic tx_plus_rail,
  output logic tx_minus_rail,
  output logic tx_line_clock_out,
  input wire logic rx_line_clock,
  input wire logic rx_plus_rail,
  input wire logic rx_minus_rail
);

  // ****************************************************
  // helpers
  // ****************************************************
  // force then invert; both set yields low
  function automatic logic shape_rail(input logic raw, input logic force_hi,
                                      input logic invert);
    shape_rail = (force_hi | raw) ^ invert;
  endfunction : shape_rail

  // register decode, one compare per mapped offset
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] offset);
    addr_hit = (addr == offset);
  endfunction : addr_hit

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic txc_level;
  logic txc_rise;
  logic txc_fall;
  logic rxc_level;
  logic rxc_rise;
  logic rxc_fall;
  logic rxp_level;
  logic rxm_level;
  logic tx_lost;

  line_sync u_txc_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(tx_input_clock),
    .level(txc_level),
    .rise(txc_rise),
    .fall(txc_fall)
  );

  line_sync u_rxc_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(rx_line_clock),
    .level(rxc_level),
    .rise(rxc_rise),
    .fall(rxc_fall)
  );

  line_sync u_rxp_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(rx_plus_rail),
    .level(rxp_level),
    .rise(),
    .fall()
  );

  line_sync u_rxm_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(rx_minus_rail),
    .level(rxm_level),
    .rise(),
    .fall()
  );

  // gaps in the transmit clock shorter than the timeout are not a loss
  activity_watch u_tx_watch (
    .pclk(pclk),
    .presetn(presetn),
    .edge_seen(txc_rise | txc_fall),
    .lost(tx_lost)
  );

  // ****************************************************
  // configuration registers
  // ****************************************************
  logic [3:0] cfg_one_q;
  logic [7:0] cfg_five_q;
  logic [2:0] irq_status_q;
  logic [2:0] irq_mask_q;
  logic [15:0] viol_q;

  logic nrz_sel;
  logic loop_on;
  logic loss_switch;
  logic tx_clk_inv;
  logic rx_clk_inv;

  assign nrz_sel = cfg_one_q[F_NRZ_SEL];
  assign loop_on = cfg_one_q[F_LINE_LOOP] | cfg_one_q[F_PAYLOAD_LOOP];
  assign loss_switch = cfg_one_q[F_LOSS_SWITCH];
  assign tx_clk_inv = cfg_five_q[F_TX_CLK_INV];
  assign rx_clk_inv = cfg_five_q[F_RX_CLK_INV];

  // ****************************************************
  // transmit clock selection
  // ****************************************************
  logic use_rx_clock;
  logic src_level;
  logic clk_out_d;
  logic clk_out_q;
  logic tx_launch;

  assign use_rx_clock = loop_on | (tx_lost & loss_switch);
  assign src_level = use_rx_clock ? rxc_level : txc_level;
  assign clk_out_d = src_level ^ tx_clk_inv;
  // launch on the active output edge: rising, or falling when inverted
  assign tx_launch = (clk_out_d != clk_out_q) &
                     (clk_out_d == ~tx_clk_inv);
  assign fmt_take = tx_launch;

  // ****************************************************
  // transmit data formatting
  // ****************************************************
  logic plus_raw;
  logic minus_raw;
  logic plus_hold_q;
  logic minus_hold_q;
  logic plus_hold_d;
  logic minus_hold_d;
  logic tx_plus_q;
  logic tx_minus_q;
  logic tx_plus_d;
  logic tx_minus_d;

  assign plus_raw = nrz_sel ? fmt_nrz : fmt_plus;
  assign minus_raw = nrz_sel ? 1'b0 : fmt_minus;
  assign plus_hold_d = tx_launch ? plus_raw : plus_hold_q;
  // binary mode drops a stale dual-rail bit at once, not at the next launch
  assign minus_hold_d = nrz_sel ? 1'b0 :
                        (tx_launch ? minus_raw : minus_hold_q);
  assign tx_plus_d = shape_rail(plus_hold_d, cfg_five_q[F_TX_PLUS_HIGH],
                                cfg_five_q[F_TX_PLUS_INV]);
  assign tx_minus_d = shape_rail(minus_hold_d, cfg_five_q[F_TX_MINUS_HIGH],
                                 cfg_five_q[F_TX_MINUS_INV]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_out_q <= 1'b0;
      plus_hold_q <= 1'b0;
      minus_hold_q <= 1'b0;
      tx_plus_q <= 1'b0;
      tx_minus_q <= 1'b0;
    end else begin
      clk_out_q <= clk_out_d;
      plus_hold_q <= plus_hold_d;
      minus_hold_q <= minus_hold_d;
      tx_plus_q <= tx_plus_d;
      tx_minus_q <= tx_minus_d;
    end
  end

  assign tx_plus_rail = tx_plus_q;
  assign tx_minus_rail = tx_minus_q;
  assign tx_line_clock_out = clk_out_q;

  // ****************************************************
  // receive capture
  // ****************************************************
  logic rx_sample;
  logic rx_plus_val;
  logic rx_minus_val;
  logic dec_plus_q;
  logic dec_minus_q;
  logic dec_strobe_q;

  // clock and data pass equal sync depth, so edge and data stay aligned
  assign rx_sample = rx_clk_inv ? rxc_fall : rxc_rise;
  assign rx_plus_val = rxp_level ^ cfg_five_q[F_RX_PLUS_INV];
  assign rx_minus_val = rxm_level ^ cfg_five_q[F_RX_MINUS_INV];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_plus_q <= 1'b0;
      dec_minus_q <= 1'b0;
      dec_strobe_q <= 1'b0;
    end else begin
      dec_strobe_q <= rx_sample;
      if (rx_sample) begin
        dec_plus_q <= rx_plus_val;
        dec_minus_q <= rx_minus_val;
      end
    end
  end

  assign dec_plus = dec_plus_q;
  assign dec_minus = dec_minus_q;
  assign dec_strobe = dec_strobe_q;

  // ****************************************************
  // violation counter
  // ****************************************************
  logic viol_event;
  logic viol_sat;
  logic viol_clear;
  logic [15:0] viol_d;

  // binary mode counts the violation pin, dual-rail the decoder's flag
  assign viol_event = nrz_sel ? (rx_sample & rx_minus_val) : dec_bpv;
  assign viol_sat = (viol_q == VIOL_MAX);

  // ****************************************************
  // apb slave
  // ****************************************************
  logic setup_ph;
  logic wr_en;
  logic hit_cfg_one;
  logic hit_cfg_five;
  logic hit_viol_low;
  logic hit_viol_high;
  logic hit_status;
  logic hit_mask;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;
  logic [2:0] irq_set;
  logic [2:0] irq_status_d;
  logic tx_lost_q;

  assign setup_ph = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign hit_cfg_one = addr_hit(paddr, ADDR_CFG_ONE);
  assign hit_cfg_five = addr_hit(paddr, ADDR_CFG_FIVE);
  assign hit_viol_low = addr_hit(paddr, ADDR_VIOL_LOW);
  assign hit_viol_high = addr_hit(paddr, ADDR_VIOL_HIGH);
  assign hit_status = addr_hit(paddr, ADDR_IRQ_STATUS);
  assign hit_mask = addr_hit(paddr, ADDR_IRQ_MASK);
  assign addr_ok = hit_cfg_one | hit_cfg_five | hit_viol_low |
                   hit_viol_high | hit_status | hit_mask;

  assign rd_mux = hit_cfg_one ? {28'h0000000, cfg_one_q} :
                  hit_cfg_five ? {24'h000000, cfg_five_q} :
                  hit_viol_low ? {24'h000000, viol_q[7:0]} :
                  hit_viol_high ? {24'h000000, viol_q[15:8]} :
                  hit_status ? {29'h00000000, irq_status_q} :
                  hit_mask ? {29'h00000000, irq_mask_q} :
                  32'h00000000;

  // writing the low byte clears the count; a count in that cycle still lands
  assign viol_clear = wr_en & hit_viol_low;
  assign viol_d = viol_clear ? {15'h0000, viol_event} :
                  (viol_event & ~viol_sat) ? viol_q + 16'h0001 : viol_q;

  assign irq_set[F_IRQ_TX_LOSS] = tx_lost & ~tx_lost_q;
  assign irq_set[F_IRQ_VIOL] = viol_event;
  // a clear in the same cycle restarts the count, so no saturation then
  assign irq_set[F_IRQ_SAT] = viol_event & ~viol_clear &
                              (viol_q == VIOL_MAX - 16'h0001);
  // set wins over a write-one clear
  assign irq_status_d = irq_set |
                        (irq_status_q & ~((wr_en & hit_status) ?
                                          pwdata[2:0] : 3'h0));

  // software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_one_q <= CFG_ONE_RST;
      cfg_five_q <= CFG_FIVE_RST;
      irq_mask_q <= IRQ_RST;
    end else begin
      if (wr_en & hit_cfg_one) begin
        cfg_one_q <= pwdata[3:0];
      end
      if (wr_en & hit_cfg_five) begin
        cfg_five_q <= pwdata[7:0];
      end
      if (wr_en & hit_mask) begin
        irq_mask_q <= pwdata[2:0];
      end
    end
  end

  // read data is captured in the setup cycle and stands through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup_ph) begin
      prdata_q <= rd_mux;
    end
  end

  // ****************************************************
  // status and counter registers
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= IRQ_RST;
      viol_q <= VIOL_RST;
      tx_lost_q <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      viol_q <= viol_d;
      tx_lost_q <= tx_lost;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign irq = |(irq_status_q & irq_mask_q);

endmodule : line_interface

// ### line_if_pkg.sv
// constants shared by the line interface block
package line_if_pkg;

  // ****************************************************
  // register byte addresses
  // ****************************************************
  localparam logic [7:0] ADDR_CFG_ONE = 8'h00;
  localparam logic [7:0] ADDR_CFG_FIVE = 8'h04;
  localparam logic [7:0] ADDR_VIOL_LOW = 8'h08;
  localparam logic [7:0] ADDR_VIOL_HIGH = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // ****************************************************
  // master_config_one fields
  // ****************************************************
  localparam int F_NRZ_SEL = 0;
  localparam int F_LINE_LOOP = 1;
  localparam int F_PAYLOAD_LOOP = 2;
  localparam int F_LOSS_SWITCH = 3;
  localparam logic [3:0] CFG_ONE_RST = 4'h0;

  // ****************************************************
  // master_config_five fields
  // ****************************************************
  localparam int F_TX_CLK_INV = 0;
  localparam int F_TX_PLUS_HIGH = 1;
  localparam int F_TX_PLUS_INV = 2;
  localparam int F_TX_MINUS_HIGH = 3;
  localparam int F_TX_MINUS_INV = 4;
  localparam int F_RX_CLK_INV = 5;
  localparam int F_RX_PLUS_INV = 6;
  localparam int F_RX_MINUS_INV = 7;
  localparam logic [7:0] CFG_FIVE_RST = 8'h00;

  // ****************************************************
  // interrupt status and mask fields
  // ****************************************************
  localparam int F_IRQ_TX_LOSS = 0;
  localparam int F_IRQ_VIOL = 1;
  localparam int F_IRQ_SAT = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // ****************************************************
  // counter and timing
  // ****************************************************
  localparam logic [15:0] VIOL_MAX = 16'hffff;
  localparam logic [15:0] VIOL_RST = 16'h0000;
  localparam int PCLK_MHZ = 250;
  localparam int TX_LOSS_NS = 200;
  localparam int TX_LOSS_CYCLES = (TX_LOSS_NS * PCLK_MHZ + 999) / 1000;
  localparam logic [7:0] TX_LOSS_COUNT = 8'(TX_LOSS_CYCLES);

endpackage : line_if_pkg

// ### line_sync.sv
// two-stage synchroniser for a pin with edge detection behind it
module line_sync
  import line_if_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_q;
  logic stable_q;
  logic prev_q;

  // only stable_q reads meta_q
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      stable_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin;
      stable_q <= meta_q;
      prev_q <= stable_q;
    end
  end

  assign level = stable_q;
  assign rise = stable_q & ~prev_q;
  assign fall = ~stable_q & prev_q;

endmodule : line_sync

// ### activity_watch.sv
// flags a clock as lost when no edge is seen for a set number of cycles
module activity_watch
  import line_if_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic edge_seen,
  output logic lost
);

  logic [7:0] idle_q;
  logic [7:0] idle_d;
  logic lost_q;
  logic lost_d;
  logic at_limit;

  assign at_limit = (idle_q == TX_LOSS_COUNT);
  assign idle_d = edge_seen ? 8'h00 : (at_limit ? idle_q : idle_q + 8'h01);
  assign lost_d = edge_seen ? 1'b0 : (lost_q | at_limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_q <= 8'h00;
      lost_q <= 1'b0;
    end else begin
      idle_q <= idle_d;
      lost_q <= lost_d;
    end
  end

  assign lost = lost_q;

endmodule : activity_watch

// ### line_if_asserts.sv
// concurrent checks on the line interface ports
module line_if_asserts
  import line_if_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic fmt_plus,
  input wire logic fmt_minus,
  input wire logic fmt_nrz,
  input wire logic fmt_take,
  input wire logic dec_plus,
  input wire logic dec_minus,
  input wire logic dec_strobe,
  input wire logic tx_input_clock,
  input wire logic tx_plus_rail,
  input wire logic tx_minus_rail,
  input wire logic tx_line_clock_out,
  input wire logic rx_line_clock,
  input wire logic rx_plus_rail,
  input wire logic rx_minus_rail
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] c1_q;
  logic [7:0] c5_q;
  logic [2:0] calm_q;
  wire wr = psel && penable && pwrite && pready;
  wire c1_wr = wr && paddr == ADDR_CFG_ONE;
  wire c5_wr = wr && paddr == ADDR_CFG_FIVE;
  // settings untouched for four cycles and not written now
  wire quiet = calm_q == 3'h4 && !c1_wr && !c5_wr;
  wire nrz = c1_q[F_NRZ_SEL];
  wire loop = c1_q[F_LINE_LOOP] || c1_q[F_PAYLOAD_LOOP];
  wire t_inv = c5_q[F_TX_CLK_INV];
  wire p_hi = c5_q[F_TX_PLUS_HIGH];
  wire p_inv = c5_q[F_TX_PLUS_INV];
  wire m_hi = c5_q[F_TX_MINUS_HIGH];
  wire m_inv = c5_q[F_TX_MINUS_INV];
  wire r_inv = c5_q[F_RX_CLK_INV];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_q <= 4'h0;
      c5_q <= 8'h00;
      calm_q <= 3'h0;
    end else begin
      if (c1_wr) c1_q <= pwdata[3:0];
      if (c5_wr) c5_q <= pwdata[7:0];
      calm_q <= (c1_wr || c5_wr) ? 3'h0 : calm_q + {2'h0, calm_q != 3'h4};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence out_active_s;
    ##3 tx_line_clock_out == !t_inv;
  endsequence
  dual_rail_data_a: assert property (
    quiet && fmt_take && !nrz && !p_hi && !m_hi |=>
    tx_plus_rail == ($past(fmt_plus) ^ p_inv) &&
    tx_minus_rail == ($past(fmt_minus) ^ m_inv))
    else $error("dual rail output wrong");
  nrz_data_a: assert property (
    quiet && fmt_take && nrz && !p_hi && !m_hi && !m_inv |=>
    tx_plus_rail == ($past(fmt_nrz) ^ p_inv) && !tx_minus_rail)
    else $error("binary output wrong");
  launch_edge_a: assert property (
    quiet && $changed(tx_plus_rail) |->
    (t_inv ? $fell(tx_line_clock_out) : $rose(tx_line_clock_out)))
    else $error("data launched off the active edge");
  plus_force_a: assert property (
    quiet && p_hi |-> tx_plus_rail == !p_inv)
    else $error("plus force wrong");
  minus_force_a: assert property (
    quiet && m_hi |-> tx_minus_rail == !m_inv)
    else $error("minus force wrong");
  clock_follow_a: assert property (
    quiet && !loop && $rose(tx_input_clock) |-> out_active_s)
    else $error("line clock not following source");
  loop_clock_a: assert property (
    quiet && loop && $rose(rx_line_clock) |-> out_active_s)
    else $error("loop clock not following receive clock");
  rx_edge_a: assert property (
    quiet && (r_inv ? $fell(rx_line_clock) : $rose(rx_line_clock))
    |-> ##3 dec_strobe)
    else $error("receive sample missed");
  rx_capture_a: assert property (
    quiet && dec_strobe |->
    dec_plus == ($past(rx_plus_rail, 3) ^ c5_q[F_RX_PLUS_INV]) &&
    dec_minus == ($past(rx_minus_rail, 3) ^ c5_q[F_RX_MINUS_INV]))
    else $error("captured receive data wrong");
endmodule : line_if_asserts

bind line_interface line_if_asserts line_if_asserts_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .pready, .paddr, .pwdata, .fmt_plus, .fmt_minus,
  .fmt_nrz, .fmt_take, .dec_plus, .dec_minus, .dec_strobe, .tx_input_clock,
  .tx_plus_rail, .tx_minus_rail, .tx_line_clock_out, .rx_line_clock,
  .rx_plus_rail, .rx_minus_rail);

// ### liu_model.sv
// line unit model: gated source clocks and pattern-driven receive rails
module liu_model (
  input wire logic pclk,
  input wire logic tx_run,
  input wire logic rx_run,
  output logic tx_input_clock,
  output logic rx_line_clock,
  output logic rx_plus_rail,
  output logic rx_minus_rail
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] tx_ph_q = 3'h0;
  logic [2:0] rx_ph_q = 3'h0;
  logic [7:0] pat_q = 8'h5b;
  // eight-cycle clocks stand low while their run input is off
  assign tx_input_clock = tx_ph_q[2];
  assign rx_line_clock = rx_ph_q[2];
  // rails change mid phase so either clock edge sees settled data
  assign rx_plus_rail = pat_q[0];
  assign rx_minus_rail = pat_q[3];
  always @(posedge pclk) begin
    tx_ph_q <= tx_run ? tx_ph_q + 3'h1 : 3'h0;
    rx_ph_q <= rx_run ? rx_ph_q + 3'h1 : 3'h0;
    if (rx_ph_q[1:0] == 2'h1) begin
      pat_q <= {pat_q[6:0], pat_q[7] ^ pat_q[5] ^ pat_q[4] ^ pat_q[3]};
    end
  end
endmodule : liu_model

// ### testbench.sv
// self-checking bench for the line interface
module testbench import line_if_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] fmt_q = 3'h5;
  logic dec_bpv = 1'b0;
  logic tx_run = 1'b0;
  logic rx_run = 1'b0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, irq, fmt_take, dec_plus, dec_minus, dec_strobe;
  logic tx_input_clock, rx_line_clock, rx_plus_rail, rx_minus_rail;
  logic tx_plus_rail, tx_minus_rail, tx_line_clock_out;
  int n_mismatch = 0;
  int n_checks = 0;
  int cnt_hi = 0;
  int cnt_lo = 0;
  int tog;
  line_interface line_interface_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .fmt_plus(fmt_q[0]), .fmt_minus(fmt_q[1]), .fmt_nrz(fmt_q[2]), .fmt_take,
    .dec_bpv, .dec_plus, .dec_minus, .dec_strobe, .tx_input_clock,
    .tx_plus_rail, .tx_minus_rail, .tx_line_clock_out, .rx_line_clock,
    .rx_plus_rail, .rx_minus_rail);
  liu_model liu_model_inst (.pclk, .tx_run, .rx_run, .tx_input_clock,
    .rx_line_clock, .rx_plus_rail, .rx_minus_rail);
  initial forever #2 pclk = ~pclk;
  always @(posedge pclk) if (fmt_take) fmt_q <= {fmt_q[1:0], ~fmt_q[2]};
  always @(posedge rx_line_clock) begin
    cnt_hi += rx_minus_rail;
    cnt_lo += !rx_minus_rail;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    if (n >= 16) begin
      n_mismatch++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    check(rdat, want);
  endtask : rd
  // counts line clock changes over 64 cycles
  task automatic toggles();
    logic last;
    tog = 0;
    repeat (64) begin
      last = tx_line_clock_out;
      @(posedge pclk);
      tog += (tx_line_clock_out !== last);
    end
  endtask : toggles
  initial begin
    #360000;
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++) begin
      rd(8'(4 * i), 32'h0);
      check(rerr, i == 6);
    end
    check(irq, 1'b0);
    tx_run <= 1'b1;
    repeat (200) @(posedge pclk);
    wr(ADDR_CFG_ONE, 32'h1);
    repeat (200) @(posedge pclk);
    wr(ADDR_CFG_ONE, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CFG_FIVE, 32'((i << 1) | (i << 3)));
      repeat (100) @(posedge pclk);
      if (i % 2 == 1) begin
        check(tx_plus_rail, i == 1);
        check(tx_minus_rail, i == 1);
      end
    end
    tx_run <= 1'b0;
    repeat (8) @(posedge pclk);
    wr(ADDR_CFG_FIVE, 32'h1);
    tx_run <= 1'b1;
    repeat (200) @(posedge pclk);
    tx_run <= 1'b0;
    repeat (8) @(posedge pclk);
    wr(ADDR_CFG_FIVE, 32'h0);
    repeat (80) @(posedge pclk);
    rd(ADDR_IRQ_STATUS, 32'h1 << F_IRQ_TX_LOSS);
    check(irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h7);
    check(irq, 1'b1);
    wr(ADDR_IRQ_STATUS, 32'h1);
    check(irq, 1'b0);
    toggles();
    check(tog, 0);
    for (int b = F_LINE_LOOP; b <= F_LOSS_SWITCH; b++) begin
      wr(ADDR_CFG_ONE, 32'h1 << b);
      rx_run <= 1'b1;
      toggles();
      check(tog != 0, 1'b1);
      rx_run <= 1'b0;
      repeat (8) @(posedge pclk);
    end
    wr(ADDR_CFG_ONE, 32'h1 << F_NRZ_SEL);
    for (int v = 0; v < 2; v++) begin
      wr(ADDR_CFG_FIVE, v ? 32'hc0 : 32'h0);
      wr(ADDR_VIOL_LOW, 32'h0);
      wr(ADDR_IRQ_STATUS, 32'h7);
      cnt_hi = 0;
      cnt_lo = 0;
      rx_run <= 1'b1;
      repeat (300) @(posedge pclk);
      rx_run <= 1'b0;
      repeat (12) @(posedge pclk);
      rd(ADDR_VIOL_LOW, v ? cnt_lo : cnt_hi);
      rd(ADDR_VIOL_HIGH, 32'h0);
      rd(ADDR_IRQ_STATUS, 32'h1 << F_IRQ_VIOL);
      check(irq, 1'b1);
    end
    rd(ADDR_CFG_FIVE, 32'hc0);
    wr(ADDR_CFG_ONE, 32'h0);
    wr(ADDR_CFG_FIVE, 32'h1 << F_RX_CLK_INV);
    wr(ADDR_VIOL_LOW, 32'h0);
    rx_run <= 1'b1;
    repeat (3) begin
      dec_bpv <= 1'b1;
      @(posedge pclk);
      dec_bpv <= 1'b0;
      @(posedge pclk);
    end
    repeat (100) @(posedge pclk);
    rx_run <= 1'b0;
    repeat (12) @(posedge pclk);
    rd(ADDR_VIOL_LOW, 32'h3);
    // hold the flag past the counter's range: it must stop at all ones
    wr(ADDR_VIOL_LOW, 32'h0);
    wr(ADDR_IRQ_STATUS, 32'h7);
    dec_bpv <= 1'b1;
    repeat (65540) @(posedge pclk);
    dec_bpv <= 1'b0;
    @(posedge pclk);
    rd(ADDR_VIOL_LOW, 32'hff);
    rd(ADDR_VIOL_HIGH, 32'hff);
    rd(ADDR_IRQ_STATUS, (32'h1 << F_IRQ_VIOL) | (32'h1 << F_IRQ_SAT));
    conclude();
  end
endmodule : testbench
